// ==== hdl/fop_top.sv ====
// Offset register programming, readback and partial flags
//
// Behaviour
// - Serial and select both low: one serial bit shifts in per write clock edge.
// - Serial enable high (serial method): offset registers hold, no bits loaded.
// - Output enable low drives output register; high floats the data bus.
// - Select at master reset: low parallel with 07FH, high serial with 3FFH.
// - Only the loading method chosen at master reset may write offsets.
// - Offsets may always be read back in parallel, either method.
// - Separate write and read pointers; master reset zeroes them, partial reset not.
// - Serial order empty low, empty high, full low, full high; 28 or 30 bits.
// - Parallel writes fill the four registers in order, fifth wraps.
// - Memory writes allowed during parallel programming; select low resumes sequence.
// - Serial programming may pause and resumes at the next bit.
// - Flag valid after its pair written (parallel) or all bits (serial).
// - Full flag valid two write edges later, empty two read edges (plus skew).
// - Parallel reads return the four registers in order, fifth wraps.
// - Readback may pause; resumes at the next register when enables low.
// - Each flag threshold comes from its own low and high register pair.
// - Parallel programming need not be one uninterrupted burst.
// - Almost full flag goes low when fill level reaches full threshold.
`timescale 1ns/100ps
module fop_top #(
    parameter int HIGH_W = 7,
    parameter int DEPTH = 32768,
    parameter int COUNT_W = 16,
    parameter bit SKEW_MET = 1'b1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic partial_reset_n,
    input wire logic write_clk,
    input wire logic read_clk,
    input wire logic register_select_n,
    input wire logic write_enable_n,
    input wire logic read_enable_n,
    input wire logic serial_load_enable_n,
    input wire logic output_drive_enable_n,
    input wire logic mode_or_serial_in,
    input wire logic [fop_pkg::DATA_W-1:0] data_in_bus,
    input wire logic [fop_pkg::DATA_W-1:0] memory_read_data,
    input wire logic [COUNT_W-1:0] fifo_word_count,
    output logic [fop_pkg::DATA_W-1:0] data_out_bus,
    output logic data_out_oe,
    output logic memory_write_strobe,
    output logic memory_read_strobe,
    output logic fall_through_mode,
    output logic serial_mode,
    output logic almost_empty_flag_n,
    output logic almost_full_flag_n,
    output logic almost_empty_valid,
    output logic almost_full_valid
);
    localparam int OFF_W = fop_pkg::LOW_W + HIGH_W;
    localparam int EMPTY_LAT = fop_pkg::FLAG_LATENCY + (SKEW_MET ? 0 : 1);

    initial begin
        if (HIGH_W < 6 || HIGH_W > fop_pkg::HIGH_W_MAX) begin
            $error("fop_top: HIGH_W must be 6 or 7");
        end
        if (DEPTH < 2 || DEPTH >= (1 << COUNT_W) * 2) begin
            $error("fop_top: DEPTH does not fit COUNT_W");
        end
    end

    logic [fop_pkg::LOW_W-1:0] thr_reg [fop_pkg::NUM_REGS];
    logic [fop_pkg::PTR_W-1:0] wr_ptr_reg;
    logic [fop_pkg::PTR_W-1:0] rd_ptr_reg;
    logic [fop_pkg::BIT_W-1:0] bit_idx_reg;
    fop_pkg::fop_load_t load_mode_reg;
    logic fall_through_reg;
    logic [fop_pkg::DATA_W-1:0] out_reg;
    logic [fop_pkg::NUM_REGS-1:0] written_reg;
    logic wr_rise;
    logic rd_rise;
    logic par_wr;
    logic ser_wr;
    logic reg_rd;
    logic mem_wr;
    logic mem_rd;
    logic ser_last_bit;
    logic empty_ready;
    logic full_ready;
    logic [OFF_W-1:0] empty_off;
    logic [OFF_W-1:0] full_off;
    logic [COUNT_W:0] count_ext;
    logic [COUNT_W:0] full_level;
    logic empty_active;
    logic full_active;

    // Width of the register at a pointer position
    function automatic logic [fop_pkg::BIT_W:0] reg_bits(input logic [fop_pkg::PTR_W-1:0] idx);
        if (idx == fop_pkg::IDX_EMPTY_HIGH || idx == fop_pkg::IDX_FULL_HIGH) begin
            return (fop_pkg::BIT_W+1)'(HIGH_W);
        end
        return (fop_pkg::BIT_W+1)'(fop_pkg::LOW_W);
    endfunction

    // Mask of storable bits at a pointer position
    function automatic logic [fop_pkg::LOW_W-1:0] reg_mask(input logic [fop_pkg::PTR_W-1:0] idx);
        logic [fop_pkg::LOW_W-1:0] m;
        m = '1;
        if (reg_bits(idx) != (fop_pkg::BIT_W+1)'(fop_pkg::LOW_W)) begin
            m = m >> (fop_pkg::LOW_W - HIGH_W);
        end
        return m;
    endfunction

    fop_edge u_wr_edge (
        .clk(clk),
        .reset_n(reset_n),
        .level(write_clk),
        .rise(wr_rise)
    );

    fop_edge u_rd_edge (
        .clk(clk),
        .reset_n(reset_n),
        .level(read_clk),
        .rise(rd_rise)
    );

    // Access decode
    assign par_wr = wr_rise && !register_select_n && !write_enable_n
                    && load_mode_reg == fop_pkg::FOP_LOAD_PARALLEL;
    assign ser_wr = wr_rise && !register_select_n && !serial_load_enable_n
                    && load_mode_reg == fop_pkg::FOP_LOAD_SERIAL;
    assign mem_wr = wr_rise && register_select_n && !write_enable_n;
    assign reg_rd = rd_rise && !register_select_n && !read_enable_n;
    assign mem_rd = rd_rise && register_select_n && !read_enable_n;
    assign ser_last_bit = bit_idx_reg == 3'(reg_bits(wr_ptr_reg) - 1'b1);

    // Loading method and timing mode caught at master reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            load_mode_reg <= register_select_n ? fop_pkg::FOP_LOAD_SERIAL
                                               : fop_pkg::FOP_LOAD_PARALLEL;
            fall_through_reg <= mode_or_serial_in;
        end
    end

    // Offset storage
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < fop_pkg::NUM_REGS; i++) begin
                if (i[0]) begin
                    thr_reg[i] <= register_select_n ? fop_pkg::SER_RESET_HIGH
                                                    : fop_pkg::PAR_RESET_HIGH;
                end else begin
                    thr_reg[i] <= register_select_n ? fop_pkg::SER_RESET_LOW
                                                    : fop_pkg::PAR_RESET_LOW;
                end
            end
        end else if (par_wr) begin
            thr_reg[wr_ptr_reg] <= data_in_bus[fop_pkg::LOW_W-1:0] & reg_mask(wr_ptr_reg);
        end else if (ser_wr) begin
            thr_reg[wr_ptr_reg][bit_idx_reg] <= mode_or_serial_in;
        end
    end

    // Write pointer, shared by both loading methods
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_ptr_reg <= fop_pkg::IDX_EMPTY_LOW;
        end else if (par_wr || (ser_wr && ser_last_bit)) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
    end

    // Serial bit position within the current register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bit_idx_reg <= '0;
        end else if (ser_wr) begin
            bit_idx_reg <= ser_last_bit ? '0 : bit_idx_reg + 1'b1;
        end
    end

    // Read pointer
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_ptr_reg <= fop_pkg::IDX_EMPTY_LOW;
        end else if (reg_rd) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end

    // Output register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            out_reg <= '0;
        end else if (reg_rd) begin
            out_reg <= {1'b0, thr_reg[rd_ptr_reg]};
        end else if (mem_rd) begin
            out_reg <= memory_read_data;
        end
    end

    // Completion tracking for flag validity
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            written_reg <= '1;
        end else if (ser_wr) begin
            written_reg <= (ser_last_bit && wr_ptr_reg == fop_pkg::IDX_FULL_HIGH)
                           ? '1 : '0;
        end else if (par_wr) begin
            if (!wr_ptr_reg[0]) begin
                written_reg[wr_ptr_reg] <= 1'b1;
                written_reg[wr_ptr_reg + 1'b1] <= 1'b0;
            end else begin
                written_reg[wr_ptr_reg] <= 1'b1;
            end
        end
    end

    assign empty_ready = written_reg[fop_pkg::IDX_EMPTY_LOW]
                         && written_reg[fop_pkg::IDX_EMPTY_HIGH];
    assign full_ready = written_reg[fop_pkg::IDX_FULL_LOW]
                        && written_reg[fop_pkg::IDX_FULL_HIGH];

    // Thresholds from each flag's register pair
    assign empty_off = {thr_reg[fop_pkg::IDX_EMPTY_HIGH][HIGH_W-1:0],
                        thr_reg[fop_pkg::IDX_EMPTY_LOW]};
    assign full_off = {thr_reg[fop_pkg::IDX_FULL_HIGH][HIGH_W-1:0],
                       thr_reg[fop_pkg::IDX_FULL_LOW]};
    assign count_ext = {1'b0, fifo_word_count};
    assign full_level = (COUNT_W+1)'(DEPTH) - (COUNT_W+1)'(full_off);
    assign empty_active = count_ext <= (COUNT_W+1)'(empty_off);
    assign full_active = count_ext >= full_level;

    fop_flag #(
        .LATENCY(fop_pkg::FLAG_LATENCY)
    ) u_full_flag (
        .clk(clk),
        .reset_n(reset_n),
        .partial_reset_n(partial_reset_n),
        .step(wr_rise),
        .ready(full_ready),
        .active(full_active),
        .flag_n(almost_full_flag_n),
        .valid(almost_full_valid)
    );

    fop_flag #(
        .LATENCY(EMPTY_LAT)
    ) u_empty_flag (
        .clk(clk),
        .reset_n(reset_n),
        .partial_reset_n(partial_reset_n),
        .step(rd_rise),
        .ready(empty_ready),
        .active(empty_active),
        .flag_n(almost_empty_flag_n),
        .valid(almost_empty_valid)
    );

    assign data_out_bus = out_reg;
    assign data_out_oe = !output_drive_enable_n;
    assign memory_write_strobe = mem_wr;
    assign memory_read_strobe = mem_rd;
    assign fall_through_mode = fall_through_reg;
    assign serial_mode = load_mode_reg == fop_pkg::FOP_LOAD_SERIAL;
endmodule

// ==== hdl/fop_pkg.sv ====
// Constants shared by the offset programming block
package fop_pkg;
    localparam int DATA_W = 9;
    localparam int LOW_W = 8;
    localparam int HIGH_W_MAX = 7;
    localparam int NUM_REGS = 4;
    localparam int PTR_W = 2;
    localparam int BIT_W = 3;
    localparam logic [PTR_W-1:0] IDX_EMPTY_LOW = 2'h0;
    localparam logic [PTR_W-1:0] IDX_EMPTY_HIGH = 2'h1;
    localparam logic [PTR_W-1:0] IDX_FULL_LOW = 2'h2;
    localparam logic [PTR_W-1:0] IDX_FULL_HIGH = 2'h3;
    localparam logic [LOW_W-1:0] PAR_RESET_LOW = 8'h7F;
    localparam logic [LOW_W-1:0] PAR_RESET_HIGH = 8'h00;
    localparam logic [LOW_W-1:0] SER_RESET_LOW = 8'hFF;
    localparam logic [LOW_W-1:0] SER_RESET_HIGH = 8'h03;
    localparam int FLAG_LATENCY = 2;
    typedef enum logic {
        FOP_LOAD_PARALLEL = 1'b0,
        FOP_LOAD_SERIAL = 1'b1
    } fop_load_t;
endpackage

// ==== hdl/fop_edge.sv ====
// Rising edge detector for a sampled clock-like input
`timescale 1ns/100ps
module fop_edge (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic level,
    output logic rise
);
    logic prev_reg;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prev_reg <= 1'b1;
        end else begin
            prev_reg <= level;
        end
    end

    assign rise = level & ~prev_reg;
endmodule

// ==== hdl/fop_flag.sv ====
// Partial flag with validity delay counted in edges of its own side
`timescale 1ns/100ps
module fop_flag #(
    parameter int LATENCY = 2
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic partial_reset_n,
    input wire logic step,
    input wire logic ready,
    input wire logic active,
    output logic flag_n,
    output logic valid
);
    logic [LATENCY-1:0] valid_sr_reg;
    logic flag_reg;

    initial begin
        if (LATENCY < 1 || LATENCY > 8) begin
            $error("fop_flag: LATENCY out of range");
        end
    end

    // Validity ripples through further edges after the offsets complete
    always_ff @(posedge clk) begin
        if (!reset_n || !partial_reset_n || !ready) begin
            valid_sr_reg <= '0;
        end else if (step) begin
            valid_sr_reg <= {valid_sr_reg[LATENCY-2 >= 0 ? LATENCY-2 : 0:0], 1'b1};
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flag_reg <= 1'b1;
        end else if (step) begin
            flag_reg <= ~active;
        end
    end

    assign valid = valid_sr_reg[LATENCY-1];
    assign flag_n = valid ? flag_reg : 1'b1;
endmodule

// ==== verif/fop_top_monitor.sv ====
// Port checker for the offset programming block
`timescale 1ns/100ps
module fop_top_monitor (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic write_clk,
    input wire logic read_clk,
    input wire logic register_select_n,
    input wire logic output_drive_enable_n,
    input wire logic [fop_pkg::DATA_W-1:0] data_out_bus,
    input wire logic data_out_oe,
    input wire logic memory_write_strobe,
    input wire logic memory_read_strobe,
    input wire logic serial_mode,
    input wire logic almost_full_flag_n,
    input wire logic almost_empty_valid,
    input wire logic almost_full_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_oe; data_out_oe == !output_drive_enable_n; endproperty
    a_oe: assert property (p_oe) else $error("oe wrong");
    property p_meth; $rose(reset_n) |-> serial_mode == $past(register_select_n); endproperty
    a_meth: assert property (p_meth) else $error("method wrong");
    property p_keep; $stable(serial_mode); endproperty
    a_keep: assert property (p_keep) else $error("method moved");
    property p_nwr; !register_select_n && !$past(register_select_n, 2) |-> !memory_write_strobe;
    endproperty
    a_nwr: assert property (p_nwr) else $error("memory write");
    property p_nrd; !register_select_n && !$past(register_select_n, 2) |-> !memory_read_strobe;
    endproperty
    a_nrd: assert property (p_nrd) else $error("memory read");
    property p_dat; $changed(data_out_bus) |-> $past(read_clk) && !$past(read_clk, 2); endproperty
    a_dat: assert property (p_dat) else $error("data moved");
    property p_fv; $rose(almost_full_valid) |-> $past(write_clk) || $past(write_clk, 2); endproperty
    a_fv: assert property (p_fv) else $error("full valid");
    property p_ev; $rose(almost_empty_valid) |-> $past(read_clk) || $past(read_clk, 2); endproperty
    a_ev: assert property (p_ev) else $error("empty valid");
    property p_fi; !almost_full_valid |-> almost_full_flag_n; endproperty
    a_fi: assert property (p_fi) else $error("flag early");
endmodule
bind fop_top fop_top_monitor u_mon (.clk(clk), .reset_n(reset_n), .write_clk(write_clk),
    .read_clk(read_clk), .register_select_n(register_select_n),
    .output_drive_enable_n(output_drive_enable_n), .data_out_bus(data_out_bus),
    .data_out_oe(data_out_oe), .memory_write_strobe(memory_write_strobe),
    .memory_read_strobe(memory_read_strobe), .serial_mode(serial_mode),
    .almost_full_flag_n(almost_full_flag_n), .almost_empty_valid(almost_empty_valid),
    .almost_full_valid(almost_full_valid));

// ==== verif/fop_host.sv ====
// Host model driving the write and read ports
`timescale 1ns/100ps
module fop_host (
    input wire logic clk,
    output logic write_clk,
    output logic read_clk,
    output logic register_select_n,
    output logic write_enable_n,
    output logic read_enable_n,
    output logic serial_load_enable_n,
    output logic mode_or_serial_in,
    output logic [fop_pkg::DATA_W-1:0] data_in_bus
);
    initial begin
        {write_clk, read_clk, write_enable_n, read_enable_n, serial_load_enable_n} = 5'h07;
        {register_select_n, mode_or_serial_in} = 2'h0;
        data_in_bus = 9'h000;
    end
    task automatic idle(input logic sel);
        @(posedge clk) #1;
        register_select_n = sel;
    endtask
    // One write clock edge; never overlaps a read edge
    task automatic wr(input logic sel, we, serial_load_enable, si, input logic [8:0] d);
        @(posedge clk) #1;
        {register_select_n, write_enable_n, serial_load_enable_n, mode_or_serial_in} =
            {sel, we, serial_load_enable, si};
        data_in_bus = d;
        @(posedge clk) #1 write_clk = 1'b1;
        repeat (2) @(posedge clk);
        #1 write_clk = 1'b0;
        @(posedge clk) #1;
        {write_enable_n, serial_load_enable_n} = 2'h3;
        mode_or_serial_in = ~si;
        data_in_bus = ~d;
        @(posedge clk);
    endtask
    task automatic rd(input logic sel, re);
        @(posedge clk) #1;
        {register_select_n, read_enable_n} = {sel, re};
        @(posedge clk) #1 read_clk = 1'b1;
        repeat (2) @(posedge clk);
        #1 read_clk = 1'b0;
        @(posedge clk) #1 read_enable_n = 1'b1;
        @(posedge clk);
    endtask
endmodule

// ==== verif/tb_fop_top.sv ====
// Self checking bench for the offset programming block
`timescale 1ns/100ps
module tb_fop_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic partial_reset_n = 1'b1;
    logic output_drive_enable_n = 1'b0;
    logic [8:0] memory_read_data = 9'h000;
    logic [15:0] fifo_word_count = 16'h0000;
    logic write_clk, read_clk, register_select_n, write_enable_n, read_enable_n;
    logic serial_load_enable_n, mode_or_serial_in, data_out_oe;
    logic [8:0] data_in_bus, data_out_bus;
    logic [15:0] rnd = 16'hAAF0;
    logic [8:0] exp_reg [4];
    logic [29:0] sv;
    logic almost_empty_flag_n, almost_full_flag_n, almost_empty_valid, almost_full_valid;
    logic memory_write_strobe, memory_read_strobe, fall_through_mode, serial_mode;
    int n_mwr = 0;
    int n_mrd = 0;
    int n_fail = 0;
    int tests_run = 0;
    always #12.5 clk = ~clk;
    // Strobe pulses counted mid cycle, away from the launching edge
    always @(negedge clk) begin
        if (memory_write_strobe === 1'b1) n_mwr++;
        if (memory_read_strobe === 1'b1) n_mrd++;
    end
    fop_host u_host (.clk(clk), .write_clk(write_clk), .read_clk(read_clk),
        .register_select_n(register_select_n), .write_enable_n(write_enable_n),
        .read_enable_n(read_enable_n), .serial_load_enable_n(serial_load_enable_n),
        .mode_or_serial_in(mode_or_serial_in), .data_in_bus(data_in_bus));
    fop_top DUT (.clk(clk), .reset_n(reset_n), .partial_reset_n(partial_reset_n),
        .write_clk(write_clk), .read_clk(read_clk), .register_select_n(register_select_n),
        .write_enable_n(write_enable_n), .read_enable_n(read_enable_n),
        .serial_load_enable_n(serial_load_enable_n),
        .output_drive_enable_n(output_drive_enable_n), .mode_or_serial_in(mode_or_serial_in),
        .data_in_bus(data_in_bus), .memory_read_data(memory_read_data),
        .fifo_word_count(fifo_word_count), .data_out_bus(data_out_bus),
        .data_out_oe(data_out_oe), .memory_write_strobe(memory_write_strobe),
        .memory_read_strobe(memory_read_strobe), .fall_through_mode(fall_through_mode),
        .serial_mode(serial_mode), .almost_empty_flag_n(almost_empty_flag_n),
        .almost_full_flag_n(almost_full_flag_n), .almost_empty_valid(almost_empty_valid),
        .almost_full_valid(almost_full_valid));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // Unused offset bits kept zero
    function automatic logic [8:0] f_mask(input int i, input logic [8:0] v);
        return i[0] ? {2'h0, v[6:0]} : {1'h0, v[7:0]};
    endfunction
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input int i);
        u_host.rd(1'b0, 1'b0);
        chk(data_out_bus, exp_reg[i]);
    endtask
    task automatic do_reset(input logic sel);
        u_host.idle(sel);
        reset_n = 1'b0;
        repeat (6) @(posedge clk);
        #1 reset_n = 1'b1;
    endtask
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        conclude();
    end
    initial begin
        do_reset(1'b0);
        exp_reg = '{9'h07F, 9'h000, 9'h07F, 9'h000};
        chk({8'h00, serial_mode}, 9'h000);
        chk({8'h00, fall_through_mode}, 9'h000);
        for (int i = 0; i < 5; i++) rd_chk(i % 4);
        #1 output_drive_enable_n = 1'b1;
        #25 chk({8'h00, data_out_oe}, 9'h000);
        output_drive_enable_n = 1'b0;
        for (int i = 0; i < 5; i++) begin
            rnd = lfsr(rnd);
            fifo_word_count = rnd;
            if (i == 2) u_host.wr(1'b1, 1'b0, 1'b1, 1'b0, rnd[8:0]);
            u_host.wr(1'b0, 1'b0, 1'b1, 1'b0, i == 0 ? 9'h1FF : rnd[8:0]);
            exp_reg[i % 4] = f_mask(i % 4, i == 0 ? 9'h1FF : rnd[8:0]);
        end
        for (int k = 1; k < 5; k++) begin
            if (k == 3) begin
                memory_read_data = rnd[9:1];
                u_host.rd(1'b1, 1'b0);
                chk(data_out_bus, memory_read_data);
            end
            rd_chk(k % 4);
        end
        repeat (3) u_host.wr(1'b0, 1'b1, 1'b0, 1'b1, 9'h000);
        rd_chk(1);
        #1 partial_reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 partial_reset_n = 1'b1;
        rd_chk(2);
        do_reset(1'b1);
        exp_reg = '{9'h0FF, 9'h003, 9'h0FF, 9'h003};
        chk({8'h00, serial_mode}, 9'h001);
        for (int i = 0; i < 4; i++) rd_chk(i);
        u_host.wr(1'b0, 1'b0, 1'b1, 1'b0, 9'h155);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            exp_reg[i] = f_mask(i, rnd[8:0]);
        end
        sv = {exp_reg[3][6:0], exp_reg[2][7:0], exp_reg[1][6:0], exp_reg[0][7:0]};
        // Full sequence, no padding, with a pause and a memory write
        for (int b = 0; b < 30; b++) begin
            if (b == 12) begin
                u_host.wr(1'b0, 1'b1, 1'b1, 1'b1, 9'h000);
                u_host.wr(1'b1, 1'b0, 1'b1, 1'b0, 9'h0A5);
            end
            u_host.wr(1'b0, 1'b1, 1'b0, sv[b], 9'h000);
        end
        rnd = lfsr(rnd);
        #1 fifo_word_count = {1'b0, rnd[15:1]};
        for (int i = 0; i < 4; i++) rd_chk(i);
        chk({8'h00, almost_empty_valid}, 9'h001);
        chk({8'h00, almost_empty_flag_n},
            {8'h00, fifo_word_count > {1'b0, exp_reg[1][6:0], exp_reg[0][7:0]}});
        chk({8'h00, almost_full_valid}, 9'h000);
        u_host.wr(1'b1, 1'b1, 1'b1, 1'b0, 9'h000);
        chk({8'h00, almost_full_valid}, 9'h000);
        u_host.wr(1'b1, 1'b1, 1'b1, 1'b0, 9'h000);
        chk({8'h00, almost_full_valid}, 9'h001);
        chk({8'h00, almost_full_flag_n}, {8'h00, !({1'b0, fifo_word_count} >=
            17'h08000 - {2'h0, exp_reg[3][6:0], exp_reg[2][7:0]})});
        chk(9'(n_mwr), 9'h002);
        chk(9'(n_mrd), 9'h001);
        conclude();
    end
endmodule
